// [etc_defs.svh]
// Offsets, field positions, reset values and codes of the tracking checker.
// Assumes a 32-bit Wishbone slave decoding byte addresses on word bounds.
`ifndef ETC_DEFS_SVH
`define ETC_DEFS_SVH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_OPERAND     8'h04
`define REG_SEG_LIMIT   8'h08
`define REG_ENV         8'h0C
`define REG_RESULT      8'h10
`define REG_FLAGS       8'h14
`define REG_FAULT       8'h18
`define REG_FAULT_ADDR  8'h1C
`define REG_EXIT_INFO   8'h20
`define REG_EXIT_GPA    8'h24
`define REG_EXIT_GLA    8'h28
`define REG_PC_BASE     8'h2C
`define REG_MAP_SEL     8'h30
`define REG_MAP_ENTRY   8'h34
`define REG_MAP_CTX     8'h38
`define REG_PEND_CLR    8'h3C

// Field positions
`define CTRL_GO_BIT     8
`define ENV_GUEST_BIT   2
`define ENV_VIRT_BIT    3
`define ENV_FEAT_BIT    4
`define ENV_TRKBSY_BIT  5
`define ENV_PGBSY_BIT   6
`define ENT_TYPE_LSB    1
`define ENT_OWNER_LSB   8
`define ENT_PEND_BIT    16
`define FLAG_CF         0
`define FLAG_ZF         6
`define PAGE_SHIFT      12

// Reset values
`define SEG_LIMIT_RST   32'hFFFFFFFF
`define PC_BASE_RST     32'h00000000

// Leaf codes, result codes, exit encodings, fault kinds
`define LEAF_EXCL       5'h0C
`define LEAF_CONC       5'h11
`define RC_OK           32'h00000000
`define RC_INVALID      32'h00000006
`define RC_CONFLICT     32'h00000007
`define RC_PRIOR_INC    32'h00000011
`define RC_NO_TRACK     32'h0000001B
`define EXIT_REASON     8'h3F
`define QUAL_RESOURCE   8'h01
`define QUAL_REFERENCE  8'h02
`define FAULT_NONE      2'h0
`define FAULT_GP        2'h1
`define FAULT_PF        2'h2
`define FAULT_UD        2'h3

`endif

// [etc_pkg.sv]
// Types shared by the tracking checker.
// Assumes etc_defs.svh supplies the numeric constants.
`default_nettype none
package etc_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_CHECK = 3'b010,
    ST_OWNER = 3'b100
  } state_e;

  // Page type encodings of the map; values are this block's own
  typedef enum logic [2:0]
  {
    PT_CONTROL = 3'h0,
    PT_THREAD  = 3'h1,
    PT_REGULAR = 3'h2,
    PT_VERSION = 3'h3,
    PT_TRIMMED = 3'h4
  } page_type_e;
endpackage
`default_nettype wire

// [enclave_tracking_cycle_checker.sv]
// Tracking cycle checker: runs the exclusive and concurrent tracking leaves
// against a flip-flop page map, reached over a classic Wishbone slave.
// Assumes the Wishbone master runs on i_clk; no input crosses clocks.
//
// Contract
// - Unaligned operand: general fault code zero
// - Operand outside page cache: page fault
// - Tracking busy: exit if virtualized, else fault
// - Exit carries reason, resource qualifier, context
// - Invalid map entry: page fault on operand
// - Non-control page type: page fault
// - Pending tracking: zero flag, prior-incomplete code
// - Success writes zero result, clears zero
// - Exclusive leaf clears remaining arithmetic flags
// - Operand beyond segment limit: general fault
// - Tracking leaves exclusive; collision reports conflict
// - Concurrent leaf: code 11H, needs feature bit
// - Both leaves only at privilege zero
// - Concurrent leaf locates control page itself
// - Shared target access; collision gives conflict
// - Concurrent conflict returns code seven
// - Invalid target page returns code six
// - Incomplete prior cycle seventeen, success zero
// - Untracked page type returns code 27
// - Carry set only for untracked type
// - Concurrent zero flag rules, others cleared
// - Owner field or self gives control page
`timescale 1ns/1ns
`default_nettype none
`include "etc_defs.svh"

module enclave_tracking_cycle_checker
  import etc_pkg::*;
#(
  parameter int N_PAGES = 16,
  parameter int IW      = $clog2(N_PAGES)
)
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [31:0] i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_done,
  output logic             o_exit
);

  localparam logic [31:0] PC_SPAN = 32'(N_PAGES) << `PAGE_SHIFT;

  // Byte-lane merge, used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Flag word with only carry and zero able to be set
  function automatic logic [11:0] flag_word(input logic cf, input logic zf);
    logic [11:0] r;
    r = 12'h000;
    r[`FLAG_CF] = cf;
    r[`FLAG_ZF] = zf;
    return r;
  endfunction

  state_e           state_reg;
  logic             ack_reg;
  logic [31:0]      dat_reg;
  logic [4:0]       leaf_reg;
  logic [31:0]      addr_reg;
  logic [31:0]      operand_reg;
  logic [31:0]      seg_limit_reg;
  logic [6:0]       env_reg;
  logic [31:0]      pc_base_reg;
  logic [IW-1:0]    map_sel_reg;
  logic [IW-1:0]    tgt_reg;
  logic [31:0]      result_reg;
  logic [11:0]      flags_reg;
  logic [1:0]       fault_reg;
  logic [31:0]      fault_addr_reg;
  logic             exit_reg;
  logic [7:0]       qual_reg;
  logic [31:0]      gpa_reg;
  logic             done_reg;
  logic             pg_valid [N_PAGES];
  page_type_e       pg_type  [N_PAGES];
  logic [IW-1:0]    pg_owner [N_PAGES];
  logic             pg_pend  [N_PAGES];
  logic [31:0]      pg_ctx   [N_PAGES];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        req;
  logic        wr_fire;
  logic [7:0]  off;
  logic [31:0] wval;
  logic        go_fire;
  assign req     = i_wb_cyc & i_wb_stb;
  assign wr_fire = req & i_wb_we & ack_reg; // Writes land on the ack edge
  assign off     = {i_wb_adr[7:2], 2'b00};
  assign go_fire = wr_fire & (off == `REG_CTRL) &
                   wval[`CTRL_GO_BIT] & (state_reg == ST_IDLE);

  // Merged write value for whichever register is addressed
  always_comb
  begin
    case (off)
      `REG_OPERAND:   wval = merge(operand_reg, i_wb_dat, i_wb_sel);
      `REG_SEG_LIMIT: wval = merge(seg_limit_reg, i_wb_dat, i_wb_sel);
      `REG_ENV:       wval = merge({25'h0, env_reg}, i_wb_dat, i_wb_sel);
      `REG_PC_BASE:   wval = merge(pc_base_reg, i_wb_dat, i_wb_sel);
      `REG_MAP_CTX:   wval = merge(pg_ctx[map_sel_reg], i_wb_dat, i_wb_sel);
      default:        wval = merge(32'h0, i_wb_dat, i_wb_sel);
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= req & ~ack_reg;
  end

  // Read data captured in the request's first cycle; unmapped reads zero
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      dat_reg <= 32'h0;
    else if (req & ~ack_reg)
    begin
      case (off)
        `REG_CTRL:       dat_reg <= {31'h0, state_reg != ST_IDLE};
        `REG_OPERAND:    dat_reg <= operand_reg;
        `REG_SEG_LIMIT:  dat_reg <= seg_limit_reg;
        `REG_ENV:        dat_reg <= {25'h0, env_reg};
        `REG_RESULT:     dat_reg <= result_reg;
        `REG_FLAGS:      dat_reg <= {20'h0, flags_reg};
        `REG_FAULT:      dat_reg <= {30'h0, fault_reg};
        `REG_FAULT_ADDR: dat_reg <= fault_addr_reg;
        `REG_EXIT_INFO:  dat_reg <= {15'h0, exit_reg, qual_reg,
                                     exit_reg ? `EXIT_REASON : 8'h00};
        `REG_EXIT_GPA:   dat_reg <= gpa_reg;
        `REG_PC_BASE:    dat_reg <= pc_base_reg;
        `REG_MAP_SEL:    dat_reg <= 32'(map_sel_reg);
        `REG_MAP_ENTRY:
          dat_reg <= (32'(pg_pend[map_sel_reg]) << `ENT_PEND_BIT)
                   | (32'(pg_owner[map_sel_reg]) << `ENT_OWNER_LSB)
                   | (32'(pg_type[map_sel_reg]) << `ENT_TYPE_LSB)
                   | 32'(pg_valid[map_sel_reg]);
        `REG_MAP_CTX:    dat_reg <= pg_ctx[map_sel_reg];
        default:         dat_reg <= 32'h0; // Includes guest-linear, always 0
      endcase
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = dat_reg;
  assign o_done   = done_reg;
  assign o_exit   = exit_reg;

  // Software-written configuration
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      operand_reg   <= 32'h0;
      seg_limit_reg <= `SEG_LIMIT_RST;
      env_reg       <= 7'h00;
      pc_base_reg   <= `PC_BASE_RST;
      map_sel_reg   <= '0;
    end
    else if (wr_fire)
    begin
      case (off)
        `REG_OPERAND:   operand_reg   <= wval;
        `REG_SEG_LIMIT: seg_limit_reg <= wval;
        `REG_ENV:       env_reg       <= wval[6:0];
        `REG_PC_BASE:   pc_base_reg   <= wval;
        `REG_MAP_SEL:   map_sel_reg   <= wval[IW-1:0];
        default:        ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Check conditions

  logic [31:0]   offs;
  logic [IW-1:0] idx;
  logic          lf_conc;
  logic          leaf_bad;
  logic          guest_virt;
  logic          pre_ok;
  logic          ex_ok;
  logic          cc_ok;
  logic          cc_is_data;
  assign offs       = addr_reg - pc_base_reg;
  assign idx        = offs[`PAGE_SHIFT +: IW];
  assign lf_conc    = (leaf_reg == `LEAF_CONC);
  assign leaf_bad   = ~((leaf_reg == `LEAF_EXCL) |
                        (lf_conc & env_reg[`ENV_FEAT_BIT]));
  assign guest_virt = env_reg[`ENV_GUEST_BIT] & env_reg[`ENV_VIRT_BIT];
  // Privilege, segment limit, alignment, residency in that order
  assign pre_ok     = ~leaf_bad & (env_reg[1:0] == 2'd0) &
                      (addr_reg <= seg_limit_reg) &
                      (addr_reg[`PAGE_SHIFT-1:0] == '0) &
                      (addr_reg >= pc_base_reg) & (offs < PC_SPAN);
  assign ex_ok      = (state_reg == ST_CHECK) & ~lf_conc & pre_ok &
                      ~env_reg[`ENV_TRKBSY_BIT] & pg_valid[idx] &
                      (pg_type[idx] == PT_CONTROL) & ~pg_pend[idx];
  assign cc_ok      = (state_reg == ST_OWNER) &
                      ~env_reg[`ENV_TRKBSY_BIT] & ~pg_pend[tgt_reg];
  assign cc_is_data = (pg_type[idx] == PT_REGULAR) |
                      (pg_type[idx] == PT_THREAD) |
                      (pg_type[idx] == PT_TRIMMED);

  ////////////////////////////////////////////////////////////////////////////
  // Page map; a hardware pending set beats a same-cycle software clear

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < N_PAGES; i++)
      begin
        pg_valid[i] <= 1'b0;
        pg_type[i]  <= PT_CONTROL;
        pg_owner[i] <= '0;
        pg_pend[i]  <= 1'b0;
        pg_ctx[i]   <= 32'h0;
      end
    end
    else
    begin
      if (wr_fire & (off == `REG_MAP_ENTRY))
      begin
        pg_valid[map_sel_reg] <= wval[0];
        pg_type[map_sel_reg]  <= page_type_e'(wval[`ENT_TYPE_LSB +: 3]);
        pg_owner[map_sel_reg] <= wval[`ENT_OWNER_LSB +: IW];
        pg_pend[map_sel_reg]  <= wval[`ENT_PEND_BIT];
      end
      if (wr_fire & (off == `REG_MAP_CTX))
        pg_ctx[map_sel_reg] <= wval;
      if (wr_fire & (off == `REG_PEND_CLR))
        pg_pend[wval[IW-1:0]] <= 1'b0; // Every processor finished the cycle
      if (ex_ok)
        pg_pend[idx] <= 1'b1;
      if (cc_ok)
        pg_pend[tgt_reg] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Leaf sequencer; one leaf at a time keeps the tracking leaves exclusive

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_reg      <= ST_IDLE;
      leaf_reg       <= 5'h0;
      addr_reg       <= 32'h0;
      tgt_reg        <= '0;
      result_reg     <= 32'h0;
      flags_reg      <= 12'h000;
      fault_reg      <= `FAULT_NONE;
      fault_addr_reg <= 32'h0;
      exit_reg       <= 1'b0;
      qual_reg       <= 8'h00;
      gpa_reg        <= 32'h0;
      done_reg       <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (go_fire) // A go while busy is dropped, CTRL shows busy
          begin
            leaf_reg  <= wval[4:0];
            addr_reg  <= operand_reg;
            fault_reg <= `FAULT_NONE;
            exit_reg  <= 1'b0;
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK:
        begin
          state_reg <= ST_IDLE;
          done_reg  <= 1'b1;
          if (leaf_bad)
            fault_reg <= `FAULT_UD;
          else if (!pre_ok)
          begin
            // Privilege, limit and alignment give GP(0), residency PF
            if ((env_reg[1:0] != 2'd0) || (addr_reg > seg_limit_reg) ||
                (addr_reg[`PAGE_SHIFT-1:0] != '0))
              fault_reg <= `FAULT_GP;
            else
            begin
              fault_reg      <= `FAULT_PF;
              fault_addr_reg <= addr_reg;
            end
          end
          else if (!lf_conc)
          begin
            if (env_reg[`ENV_TRKBSY_BIT])
            begin
              if (guest_virt)
              begin
                exit_reg <= 1'b1;
                qual_reg <= `QUAL_RESOURCE;
                gpa_reg  <= pg_ctx[idx];
              end
              else
                fault_reg <= `FAULT_GP;
            end
            else if (!pg_valid[idx] || (pg_type[idx] != PT_CONTROL))
            begin
              fault_reg      <= `FAULT_PF;
              fault_addr_reg <= addr_reg;
            end
            else if (pg_pend[idx])
            begin
              if (guest_virt)
              begin
                exit_reg <= 1'b1;
                qual_reg <= `QUAL_REFERENCE;
                gpa_reg  <= pg_ctx[idx];
              end
              result_reg <= `RC_PRIOR_INC;
              flags_reg  <= flag_word(1'b0, 1'b1);
            end
            else
            begin
              result_reg <= `RC_OK;
              flags_reg  <= flag_word(1'b0, 1'b0);
            end
          end
          else if (env_reg[`ENV_PGBSY_BIT])
          begin
            result_reg <= `RC_CONFLICT;
            flags_reg  <= flag_word(1'b0, 1'b1);
          end
          else if (!pg_valid[idx])
          begin
            result_reg <= `RC_INVALID;
            flags_reg  <= flag_word(1'b0, 1'b1);
          end
          else if (cc_is_data || (pg_type[idx] == PT_CONTROL))
          begin
            // Control page through the owner field, or the page itself
            tgt_reg   <= cc_is_data ? pg_owner[idx] : idx;
            state_reg <= ST_OWNER;
            done_reg  <= 1'b0;
          end
          else
          begin
            result_reg <= `RC_NO_TRACK;
            flags_reg  <= flag_word(1'b1, 1'b0);
          end
        end
        ST_OWNER:
        begin
          state_reg <= ST_IDLE;
          done_reg  <= 1'b1;
          if (env_reg[`ENV_TRKBSY_BIT] || pg_pend[tgt_reg])
          begin
            // Exit is reported only when virtualized, and the leaf still returns its code on the same edge
            if (guest_virt)
            begin
              exit_reg <= 1'b1;
              qual_reg <= env_reg[`ENV_TRKBSY_BIT] ? `QUAL_RESOURCE
                                                    : `QUAL_REFERENCE;
              gpa_reg  <= pg_ctx[tgt_reg];
            end
            result_reg <= env_reg[`ENV_TRKBSY_BIT] ? `RC_CONFLICT
                                                    : `RC_PRIOR_INC;
            flags_reg  <= flag_word(1'b0, 1'b1);
          end
          else
          begin
            result_reg <= `RC_OK;
            flags_reg  <= flag_word(1'b0, 1'b0);
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic chk_ex;
  assign chk_ex = (state_reg == ST_CHECK) & ~lf_conc & pre_ok;

  sequence s_go_conc;
    go_fire && (wval[4:0] == `LEAF_CONC) ##1 (state_reg == ST_CHECK);
  endsequence

  property p_align;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_reg == ST_CHECK) && !leaf_bad && (env_reg[1:0] == 2'd0) &&
    (addr_reg <= seg_limit_reg) && (addr_reg[11:0] != 12'h000)
    |=> (fault_reg == `FAULT_GP) && done_reg && !$changed(result_reg);
  endproperty
  a_align: assert property (p_align) else $error("unaligned not GP");

  property p_nonres;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_reg == ST_CHECK) && !leaf_bad && (env_reg[1:0] == 2'd0) &&
    (addr_reg <= seg_limit_reg) && (addr_reg[11:0] == 12'h000) && !pre_ok
    |=> (fault_reg == `FAULT_PF) && (fault_addr_reg == $past(addr_reg));
  endproperty
  a_nonres: assert property (p_nonres) else $error("no page fault");

  property p_res_exit;
    @(posedge i_clk) disable iff (i_sys_rst)
    chk_ex && env_reg[`ENV_TRKBSY_BIT] && guest_virt
    |=> exit_reg && (qual_reg == `QUAL_RESOURCE) &&
        (gpa_reg == $past(pg_ctx[idx])) && (fault_reg == `FAULT_NONE);
  endproperty
  a_res_exit: assert property (p_res_exit) else $error("bad exit");

  property p_res_gp;
    @(posedge i_clk) disable iff (i_sys_rst)
    chk_ex && env_reg[`ENV_TRKBSY_BIT] && !guest_virt
    |=> (fault_reg == `FAULT_GP) && !exit_reg;
  endproperty
  a_res_gp: assert property (p_res_gp) else $error("conflict not GP");

  property p_prior;
    @(posedge i_clk) disable iff (i_sys_rst)
    chk_ex && !env_reg[`ENV_TRKBSY_BIT] && pg_valid[idx] &&
    (pg_type[idx] == PT_CONTROL) && pg_pend[idx]
    |=> (result_reg == 32'h11) && (flags_reg == 12'h040);
  endproperty
  a_prior: assert property (p_prior) else $error("prior code");

  property p_success;
    @(posedge i_clk) disable iff (i_sys_rst)
    ex_ok |=> (result_reg == 32'h0) && (flags_reg == 12'h000) &&
              pg_pend[$past(idx)] && (state_reg == ST_IDLE);
  endproperty
  a_success: assert property (p_success) else $error("success");

  property p_priv;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_reg == ST_CHECK) && !leaf_bad && (env_reg[1:0] != 2'd0)
    |=> (fault_reg == `FAULT_GP) && !exit_reg;
  endproperty
  a_priv: assert property (p_priv) else $error("privilege");

  property p_conc_run;
    @(posedge i_clk) disable iff (i_sys_rst)
    s_go_conc |-> ##[1:2] done_reg;
  endproperty
  a_conc_run: assert property (p_conc_run) else $error("no finish");

  property p_conc_busy;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_reg == ST_CHECK) && lf_conc && pre_ok && env_reg[`ENV_PGBSY_BIT]
    |=> (result_reg == 32'h7) && (flags_reg == 12'h040);
  endproperty
  a_conc_busy: assert property (p_conc_busy) else $error("code 7");

  property p_conc_inval;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_reg == ST_CHECK) && lf_conc && pre_ok &&
    !env_reg[`ENV_PGBSY_BIT] && !pg_valid[idx]
    |=> (result_reg == 32'h6) && flags_reg[`FLAG_ZF];
  endproperty
  a_conc_inval: assert property (p_conc_inval) else $error("code 6");

  property p_no_track;
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_reg == ST_CHECK) && lf_conc && pre_ok &&
    !env_reg[`ENV_PGBSY_BIT] && pg_valid[idx] && !cc_is_data &&
    (pg_type[idx] != PT_CONTROL)
    |=> (result_reg == 32'h1B) && (flags_reg == 12'h001);
  endproperty
  a_no_track: assert property (p_no_track) else $error("code 27");

  property p_ack;
    @(posedge i_clk) disable iff (i_sys_rst)
    ack_reg |=> !ack_reg;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held");

endmodule
`default_nettype wire

// [test_enclave_tracking_cycle_checker.sv]
// Self-checking bench for the tracking cycle checker.
// Assumes the register map and Wishbone timing of etc_defs.svh.
`timescale 1ns/1ns
`default_nettype none
`include "etc_defs.svh"

module test_enclave_tracking_cycle_checker;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [31:0] adr = '0;
  logic [31:0] dat = '0;
  logic [3:0]  sel = '0;
  logic [31:0] rdat;
  logic        ack;
  logic        done;
  logic        vexit;
  logic [31:0] q;
  int          fails = 0;
  int          n_checks = 0;

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end

  ////////////////////////////////////////////////////////////////////////
  // Clock and device
  always #5 clk = ~clk;

  enclave_tracking_cycle_checker #(.N_PAGES(16)) dut_u (
    .i_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_done(done), .o_exit(vexit));

  ////////////////////////////////////////////////////////////////////////
  // Verdict, the only place the run ends
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Classic cycle; ack is seen before the edge's own updates land
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {24'h0, a};
    dat <= d;
    sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      fails++;
      end_sim();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask

  task automatic ent(input logic [7:0] i, input logic [31:0] v);
    wb(1'b1, `REG_MAP_SEL, {24'h0, i});
    wb(1'b1, `REG_MAP_ENTRY, v);
  endtask

  // Issue a leaf, wait for its done pulse, judge fault, exit, result
  task automatic leaf(input logic [4:0] c, input logic [31:0] op,
                      input logic [1:0] ef, input logic [31:0] er,
                      input logic [31:0] efl, input logic ex);
    int n;
    wb(1'b1, `REG_OPERAND, op);
    wb(1'b1, `REG_CTRL, {23'h0, 1'b1, 3'h0, c});
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (done !== 1'b1 && n < 20);
    `CHK(done, 1'b1)
    if (done !== 1'b1)
      end_sim();
    `CHK(vexit, ex)
    // Done is a single-cycle pulse
    @(posedge clk);
    `CHK(done, 1'b0)
    rd(`REG_FAULT, {30'h0, ef});
    if (ef == `FAULT_NONE)
    begin
      rd(`REG_RESULT, er);
      rd(`REG_FLAGS, efl);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped hole, page map set-up
  task automatic t_regs;
    rd(`REG_SEG_LIMIT, `SEG_LIMIT_RST);
    rd(`REG_FAULT, 32'h0);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    ent(8'h00, 32'h00000001);
    wb(1'b1, `REG_MAP_CTX, 32'h0000ABC0);
    ent(8'h01, 32'h00000005);
    ent(8'h02, 32'h00000003);
    ent(8'h03, 32'h00000007);
    rd(`REG_MAP_ENTRY, 32'h00000007);
  endtask

  // Exclusive leaf checks in priority order, then success and repeat
  task automatic t_excl;
    wb(1'b1, `REG_ENV, 32'h10);
    leaf(`LEAF_EXCL, 32'h1004, `FAULT_GP, 0, 0, 0);
    leaf(`LEAF_EXCL, 32'h10000, `FAULT_PF, 0, 0, 0);
    rd(`REG_FAULT_ADDR, 32'h10000);
    leaf(`LEAF_EXCL, 32'h4000, `FAULT_PF, 0, 0, 0);
    leaf(`LEAF_EXCL, 32'h2000, `FAULT_PF, 0, 0, 0);
    leaf(`LEAF_EXCL, 32'h0, `FAULT_NONE, `RC_OK, 32'h0, 0);
    leaf(`LEAF_EXCL, 32'h0, `FAULT_NONE, `RC_PRIOR_INC, 32'h40, 0);
    leaf(`LEAF_CONC, 32'h1000, `FAULT_NONE, `RC_PRIOR_INC, 32'h40, 0);
    wb(1'b1, `REG_PEND_CLR, 32'h0);
    leaf(`LEAF_CONC, 32'h1000, `FAULT_NONE, `RC_OK, 32'h0, 0);
  endtask

  // Concurrent leaf outcomes; owner page stays pending from above
  task automatic t_conc;
    leaf(`LEAF_CONC, 32'h3000, `FAULT_NONE, `RC_NO_TRACK, 32'h1, 0);
    leaf(`LEAF_CONC, 32'h4000, `FAULT_NONE, `RC_INVALID, 32'h40, 0);
    leaf(`LEAF_CONC, 32'h2000, `FAULT_NONE, `RC_PRIOR_INC, 32'h40, 0);
    wb(1'b1, `REG_ENV, 32'h50);
    leaf(`LEAF_CONC, 32'h1000, `FAULT_NONE, `RC_CONFLICT, 32'h40,
         0);
    wb(1'b1, `REG_ENV, 32'h30);
    leaf(`LEAF_CONC, 32'h1000, `FAULT_NONE, `RC_CONFLICT, 32'h40,
         0);
  endtask

  // Tracking resource busy, bare and virtualized; pending exit;
  // then carry cleared by a later success, and a moved cache base
  task automatic t_busy;
    leaf(`LEAF_EXCL, 32'h0, `FAULT_GP, 0, 0, 0);
    wb(1'b1, `REG_ENV, 32'h3C);
    leaf(`LEAF_EXCL, 32'h0, `FAULT_NONE, `RC_CONFLICT, 32'h40, 1);
    rd(`REG_EXIT_INFO, 32'h0001013F);
    rd(`REG_EXIT_GPA, 32'h0000ABC0);
    rd(`REG_EXIT_GLA, 32'h0);
    wb(1'b1, `REG_ENV, 32'h1C);
    leaf(`LEAF_EXCL, 32'h0, `FAULT_NONE, `RC_PRIOR_INC, 32'h40, 1);
    rd(`REG_EXIT_INFO, 32'h0001023F);
    wb(1'b1, `REG_ENV, 32'h10);
    wb(1'b1, `REG_PEND_CLR, 32'h0);
    leaf(`LEAF_CONC, 32'h3000, `FAULT_NONE, `RC_NO_TRACK, 32'h1, 0);
    leaf(`LEAF_EXCL, 32'h0, `FAULT_NONE, `RC_OK, 32'h0, 0);
    wb(1'b1, `REG_PC_BASE, 32'h00010000);
    leaf(`LEAF_EXCL, 32'h0, `FAULT_PF, 0, 0, 0);
    rd(`REG_FAULT_ADDR, 32'h0);
    leaf(`LEAF_EXCL, 32'h10000, `FAULT_NONE, `RC_PRIOR_INC, 32'h40, 0);
  endtask

  // Privilege, feature bit, unknown leaf, segment limit
  task automatic t_refuse;
    wb(1'b1, `REG_ENV, 32'h13);
    leaf(`LEAF_EXCL, 32'h0, `FAULT_GP, 0, 0, 0);
    leaf(`LEAF_CONC, 32'h1000, `FAULT_GP, 0, 0, 0);
    wb(1'b1, `REG_ENV, 32'h0);
    leaf(`LEAF_CONC, 32'h1000, `FAULT_UD, 0, 0, 0);
    leaf(5'h01, 32'h0, `FAULT_UD, 0, 0, 0);
    wb(1'b1, `REG_ENV, 32'h10);
    wb(1'b1, `REG_SEG_LIMIT, 32'h00000FFF);
    leaf(`LEAF_EXCL, 32'h1000, `FAULT_GP, 0, 0, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_excl();
    t_conc();
    t_busy();
    t_refuse();
    end_sim();
  end
endmodule
`default_nettype wire
